// file: hdl/hsq_sequencer.sv
`timescale 1ns/1ps
module hsq_sequencer
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Command
  input wire logic start_in,
  input wire logic [7:0] method_in,
  input wire logic [hsq_pkg::SPD_W-1:0] high_speed_in,
  input wire logic [hsq_pkg::SPD_W-1:0] low_speed_in,
  input wire logic signed [hsq_pkg::POS_W-1:0] position_in,
  // Switch pins, asynchronous
  input wire hsq_pkg::hsq_switch_t switch_in,
  // Motion loop and status
  output hsq_pkg::hsq_motion_t motion_out,
  output hsq_pkg::hsq_status_t status_out,
  output logic signed [hsq_pkg::POS_W-1:0] origin_out
);
  import hsq_pkg::*;

  typedef enum logic [2:0] {
    HSQ_IDLE, HSQ_SEARCH, HSQ_PH1, HSQ_PH2, HSQ_PH3
  } hsq_state_t;

  hsq_switch_t sync1_q, sync2_q, prev_q;
  hsq_state_t state_q, state_d;
  logic [7:0] method_q, method_d;
  logic [SPD_W-1:0] high_q, high_d, low_q, low_d;
  logic dir_q, dir_d;
  hsq_speed_t spd_q, spd_d;
  logic done_q, done_d, rej_q, rej_d;
  logic signed [POS_W-1:0] origin_q, origin_d;
  logic rise, fall;

  // Switch pins pass two flops before any decision looks at them
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= switch_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q.home && !prev_q.home;
  assign fall = !sync2_q.home && prev_q.home;

  always_comb
  begin
    state_d = state_q;
    method_d = method_q;
    high_d = high_q;
    low_d = low_q;
    dir_d = dir_q;
    spd_d = spd_q;
    done_d = done_q;
    rej_d = rej_q;
    origin_d = origin_q;
    case (state_q)
      HSQ_IDLE:
      begin
        if (start_in)
        begin
          done_d = 1'b0;
          rej_d = 1'b0;
          method_d = method_in;
          // Speeds are frozen at start so a mid-run change cannot jerk the axis
          high_d = high_speed_in;
          low_d = low_speed_in;
          if (method_in == METHOD_31 || method_in == METHOD_32)
          begin
            rej_d = 1'b1;
          end
          else if (method_in != METHOD_28 && method_in != METHOD_29
                   && method_in != METHOD_30)
          begin
            rej_d = 1'b1;
          end
          else if (sync2_q.home)
          begin
            // Switch already active: skip the fast search
            state_d = HSQ_PH2;
            spd_d = HSQ_LOW;
            dir_d = (method_in == METHOD_28) ? DIR_POS : DIR_NEG;
          end
          else
          begin
            state_d = HSQ_SEARCH;
            spd_d = HSQ_HIGH;
            dir_d = DIR_NEG;
          end
        end
      end
      HSQ_SEARCH:
      begin
        if (rise)
        begin
          state_d = HSQ_PH1;
          spd_d = HSQ_LOW;
          // Slow direction after the first home edge follows the method alone
          if (method_q == METHOD_28)
          begin
            dir_d = DIR_POS;
          end
          else if (method_q == METHOD_29)
          begin
            dir_d = DIR_NEG;
          end
          else
          begin
            dir_d = DIR_NEG;
          end
        end
        else if (sync2_q.neg_limit && dir_q == DIR_NEG)
        begin
          dir_d = DIR_POS;
        end
      end
      HSQ_PH1:
      begin
        if (fall)
        begin
          if (method_q == METHOD_30)
          begin
            state_d = HSQ_PH3;
          end
          else
          begin
            state_d = HSQ_PH2;
            dir_d = (method_q == METHOD_28) ? DIR_NEG : DIR_POS;
          end
        end
      end
      HSQ_PH2:
      begin
        if (method_q == METHOD_30 && fall)
        begin
          state_d = HSQ_PH3;
        end
        else if (method_q != METHOD_30 && fall)
        begin
          dir_d = (method_q == METHOD_28) ? DIR_NEG : DIR_POS;
        end
        else if (method_q != METHOD_30 && rise)
        begin
          state_d = HSQ_PH3;
        end
      end
      default:
      begin
        // Terminating edge seen one cycle earlier
        state_d = HSQ_IDLE;
        spd_d = HSQ_STOP;
        done_d = 1'b1;
        origin_d = position_in;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q <= HSQ_IDLE;
      method_q <= '0;
      high_q <= '0;
      low_q <= '0;
      dir_q <= DIR_NEG;
      spd_q <= HSQ_STOP;
      done_q <= 1'b0;
      rej_q <= 1'b0;
      origin_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      method_q <= method_d;
      high_q <= high_d;
      low_q <= low_d;
      dir_q <= dir_d;
      spd_q <= spd_d;
      done_q <= done_d;
      rej_q <= rej_d;
      origin_q <= origin_d;
    end
  end

  // Stop state is entered one cycle after the edge is seen; magnitude is zeroed there before spd_q reaches HSQ_STOP
  assign motion_out.magnitude = (spd_q == HSQ_HIGH) ? high_q
                              : ((spd_q == HSQ_LOW && state_q != HSQ_PH3) ? low_q : '0);
  assign motion_out.dir_pos = dir_q;
  assign status_out.busy = (state_q != HSQ_IDLE);
  assign status_out.done = done_q;
  assign status_out.rejected = rej_q;
  assign origin_out = origin_q;

  property p_stop_at_end;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH3) |-> (motion_out.magnitude == '0) ##1 (done_q && state_q == HSQ_IDLE);
  endproperty
  a_stop_at_end: assert property (p_stop_at_end) else $error("no stop at end");

  property p_reserved;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_IDLE && start_in && (method_in == METHOD_31 || method_in == METHOD_32))
      |=> (state_q == HSQ_IDLE && rej_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved method ran");

  property p_choose;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_IDLE && start_in && method_in == METHOD_30 && sync2_q.home)
      |=> (state_q == HSQ_PH2 && dir_q == DIR_NEG && spd_q == HSQ_LOW);
  endproperty
  a_choose: assert property (p_choose) else $error("wrong start sequence");

  property p_search_fast;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_SEARCH) |-> (motion_out.magnitude == high_q);
  endproperty
  a_search_fast: assert property (p_search_fast) else $error("search not fast");

  property p_limit_turn;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_SEARCH && !rise && sync2_q.neg_limit) |=> (dir_q == DIR_POS);
  endproperty
  a_limit_turn: assert property (p_limit_turn) else $error("no turn at limit");

  property p_m28_rise;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_SEARCH && rise && method_q == METHOD_28) |=> (dir_q == DIR_POS && spd_q == HSQ_LOW);
  endproperty
  a_m28_rise: assert property (p_m28_rise) else $error("m28 slow wrong");

  property p_m29_rise;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_SEARCH && rise && method_q == METHOD_29) |=> (dir_q == DIR_NEG);
  endproperty
  a_m29_rise: assert property (p_m29_rise) else $error("m29 slow wrong");

  property p_m30_fall;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH1 && fall && method_q == METHOD_30) |=> (state_q == HSQ_PH3 && dir_q == DIR_NEG);
  endproperty
  a_m30_fall: assert property (p_m30_fall) else $error("m30 no stop");

  property p_m28_start_on;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_IDLE && start_in && method_in == METHOD_28 && sync2_q.home)
      |=> (state_q == HSQ_PH2 && dir_q == DIR_POS && spd_q == HSQ_LOW);
  endproperty
  a_m28_start_on: assert property (p_m28_start_on) else $error("m28 start wrong");

  property p_m29_start_on;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_IDLE && start_in && method_in == METHOD_29 && sync2_q.home)
      |=> (state_q == HSQ_PH2 && dir_q == DIR_NEG && spd_q == HSQ_LOW);
  endproperty
  a_m29_start_on: assert property (p_m29_start_on) else $error("m29 start wrong");

  property p_search_entry;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_IDLE && start_in && !sync2_q.home
      && (method_in == METHOD_28 || method_in == METHOD_29 || method_in == METHOD_30))
      |=> (state_q == HSQ_SEARCH && dir_q == DIR_NEG && spd_q == HSQ_HIGH);
  endproperty
  a_search_entry: assert property (p_search_entry) else $error("bad search start");

  property p_m28_leave;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH1 && fall && method_q == METHOD_28)
      |=> (state_q == HSQ_PH2 && dir_q == DIR_NEG);
  endproperty
  a_m28_leave: assert property (p_m28_leave) else $error("m28 no turn back");

  property p_m29_leave;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH1 && fall && method_q == METHOD_29)
      |=> (state_q == HSQ_PH2 && dir_q == DIR_POS);
  endproperty
  a_m29_leave: assert property (p_m29_leave) else $error("m29 no turn back");

  property p_m28_turn;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH2 && fall && method_q == METHOD_28) |=> (dir_q == DIR_NEG);
  endproperty
  a_m28_turn: assert property (p_m28_turn) else $error("m28 no reverse");

  property p_m29_turn;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH2 && fall && method_q == METHOD_29) |=> (dir_q == DIR_POS);
  endproperty
  a_m29_turn: assert property (p_m29_turn) else $error("m29 no reverse");

  property p_m30_on_stop;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH2 && fall && method_q == METHOD_30) |=> (state_q == HSQ_PH3);
  endproperty
  a_m30_on_stop: assert property (p_m30_on_stop) else $error("m30 no halt");

  property p_final_rise;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH2 && rise && method_q != METHOD_30) |=> (state_q == HSQ_PH3);
  endproperty
  a_final_rise: assert property (p_final_rise) else $error("no halt on rise");

  property p_origin;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_PH3) |=> (origin_out == $past(position_in) && status_out.done);
  endproperty
  a_origin: assert property (p_origin) else $error("origin not taken");

  property p_idle_still;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == HSQ_IDLE) |-> (motion_out.magnitude == '0);
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("motion while idle");

  property p_speed_frozen;
    @(posedge clk_in) disable iff (reset_in)
    (state_q != HSQ_IDLE) |=> ($stable(high_q) && $stable(low_q));
  endproperty
  a_speed_frozen: assert property (p_speed_frozen) else $error("speed changed mid run");

endmodule // hsq_sequencer

// file: hdl/hsq_pkg.sv
package hsq_pkg;
  localparam int SPD_W = 16;
  localparam int POS_W = 32;
  localparam logic [7:0] METHOD_28 = 8'h1c;
  localparam logic [7:0] METHOD_29 = 8'h1d;
  localparam logic [7:0] METHOD_30 = 8'h1e;
  localparam logic [7:0] METHOD_31 = 8'h1f;
  localparam logic [7:0] METHOD_32 = 8'h20;
  localparam logic DIR_POS = 1'b1;
  localparam logic DIR_NEG = 1'b0;

  typedef enum logic [1:0] {HSQ_STOP, HSQ_LOW, HSQ_HIGH} hsq_speed_t;

  typedef struct packed {
    logic home;
    logic neg_limit;
  } hsq_switch_t;

  typedef struct packed {
    logic [SPD_W-1:0] magnitude;
    logic dir_pos;
  } hsq_motion_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic rejected;
  } hsq_status_t;
endpackage

// file: testbench/hsq_motion_model.sv
`timescale 1ns/1ps
module hsq_motion_model
#(
  parameter int HOME_LO = 100,
  parameter int HOME_HI = 200
)
(
  // Clock, reset and preset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic signed [hsq_pkg::POS_W-1:0] load_pos_in,
  // Motion command
  input wire hsq_pkg::hsq_motion_t motion_in,
  // Axis state
  output logic signed [hsq_pkg::POS_W-1:0] position_out,
  output hsq_pkg::hsq_switch_t switch_out,
  output hsq_pkg::hsq_motion_t first_out,
  output hsq_pkg::hsq_motion_t last_out
);
  import hsq_pkg::*;
  logic signed [POS_W-1:0] step;
  assign step = $signed({16'h0000, motion_in.magnitude});
  always_ff @(posedge clk_in)
  begin
    if (reset_in || load_in)
    begin
      position_out <= reset_in ? '0 : load_pos_in;
      first_out <= '0;
      last_out <= '0;
    end
    else if (motion_in.magnitude != '0)
    begin
      position_out <= motion_in.dir_pos ? position_out + step : position_out - step;
      if (first_out.magnitude == '0)
        first_out <= motion_in;
      last_out <= motion_in;
    end
  end
  // Cam band for home; the limit stays tripped while at or below zero
  assign switch_out.home = position_out >= HOME_LO && position_out <= HOME_HI;
  assign switch_out.neg_limit = position_out <= 0;
endmodule // hsq_motion_model

// file: testbench/test_homing_sequencer_methods_28_30.sv
`timescale 1ns/1ps
module test_homing_sequencer_methods_28_30;
  import hsq_pkg::*;
  localparam logic [15:0] HI = 16'h0008;
  localparam logic [15:0] LO = 16'h0001;
  logic [SPD_W-1:0] hi_spd = HI, lo_spd = LO;
  logic clk_in = 0, reset_in = 1, start_in = 0, load = 0;
  logic [7:0] method_in = '0;
  logic signed [POS_W-1:0] load_pos = '0, position, origin;
  hsq_switch_t switches;
  hsq_motion_t motion, first_mv, last_mv;
  hsq_status_t status;
  int errors = 0, comparisons = 0, cycles = 0;

  hsq_sequencer hsq_sequencer_i (.clk_in(clk_in), .reset_in(reset_in), .start_in(start_in),
    .method_in(method_in), .high_speed_in(hi_spd), .low_speed_in(lo_spd), .position_in(position),
    .switch_in(switches), .motion_out(motion), .status_out(status), .origin_out(origin));
  hsq_motion_model hsq_motion_model_i (.clk_in(clk_in), .reset_in(reset_in), .load_in(load),
    .load_pos_in(load_pos), .motion_in(motion), .position_out(position),
    .switch_out(switches), .first_out(first_mv), .last_out(last_mv));

  initial
    forever #50 clk_in = ~clk_in;

  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude;
    end
  end

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Origin lands a few counts past the cam edge because of the sync delay
  task automatic run_home(input logic [7:0] m, input int p0, input logic [15:0] mag0,
    input logic dir0, input int org, input logic dir_end);
    int n;
    @(posedge clk_in);
    #1 load = 1;
    load_pos = p0;
    method_in = m;
    hi_spd = HI;
    lo_spd = LO;
    @(posedge clk_in);
    #1 load = 0;
    repeat (4) @(posedge clk_in);
    #1 start_in = 1;
    @(posedge clk_in);
    #1 start_in = 0;
    // Inputs move once started; the values taken at start must keep ruling
    hi_spd = 16'h0003;
    lo_spd = 16'h0002;
    check(status.busy === 1'b1 && status.rejected === 1'b0, "start not taken");
    for (n = 0; n < 5000 && status.done !== 1'b1; n++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
    check(status.busy === 1'b0 && motion.magnitude === 16'h0000, "motion not halted");
    check(status.done === 1'b1 && status.rejected === 1'b0, "no completion flag");
    check(first_mv.magnitude === mag0 && first_mv.dir_pos === dir0, "wrong opening move");
    check(last_mv.magnitude === LO && last_mv.dir_pos === dir_end, "wrong final approach");
    check(origin === position && origin >= org - 6 && origin <= org + 6, "bad origin");
  endtask

  task automatic sc_method_28;
    run_home(METHOD_28, 400, HI, DIR_NEG, 200, DIR_NEG);
    run_home(METHOD_28, 150, LO, DIR_POS, 200, DIR_NEG);
    run_home(METHOD_28, 60, HI, DIR_NEG, 200, DIR_NEG);
  endtask

  task automatic sc_method_29;
    run_home(METHOD_29, 400, HI, DIR_NEG, 100, DIR_POS);
    run_home(METHOD_29, 150, LO, DIR_NEG, 100, DIR_POS);
    run_home(METHOD_29, 60, HI, DIR_NEG, 100, DIR_POS);
  endtask

  task automatic sc_method_30;
    run_home(METHOD_30, 400, HI, DIR_NEG, 100, DIR_NEG);
    run_home(METHOD_30, 150, LO, DIR_NEG, 100, DIR_NEG);
    run_home(METHOD_30, 60, HI, DIR_NEG, 100, DIR_NEG);
  endtask

  task automatic sc_reserved;
    logic [7:0] codes [3] = '{METHOD_31, METHOD_32, 8'h1b};
    foreach (codes[i])
    begin
      @(posedge clk_in);
      #1 method_in = codes[i];
      start_in = 1;
      @(posedge clk_in);
      #1 start_in = 0;
      repeat (3) @(negedge clk_in);
      check(status.rejected === 1'b1 && status.busy === 1'b0, "code not refused");
      check(motion.magnitude === 16'h0000, "refused code moved");
    end
  endtask

  initial
  begin
    repeat (6) @(posedge clk_in);
    #1 reset_in = 0;
    sc_method_28;
    sc_method_29;
    sc_method_30;
    sc_reserved;
    conclude;
  end
endmodule // test_homing_sequencer_methods_28_30
